// File: hdl/acq_trig_pkg.sv
// Package: register map, field layout and types for the acquisition trigger control
package acq_trig_pkg;
   // APB register byte offsets
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] SAMP_DIV_OFS  = 8'h04;
   localparam logic [7:0] POST_CNT_OFS  = 8'h08;
   localparam logic [7:0] SCAN_DIV_OFS  = 8'h0C;
   localparam logic [7:0] DAC0_OFS      = 8'h10;
   localparam logic [7:0] DAC1_OFS      = 8'h14;
   localparam logic [7:0] STATUS_OFS    = 8'h18;
   localparam logic [7:0] IRQ_STAT_OFS  = 8'h1C;
   localparam logic [7:0] IRQ_MASK_OFS  = 8'h20;

   // Control register bit positions
   localparam int CTRL_ARM_BIT   = 0;
   localparam int CTRL_EXTCV_BIT = 1;
   localparam int CTRL_STOPM_BIT = 2;
   localparam int CTRL_SCAN_BIT  = 3;
   localparam int CTRL_EXTSC_BIT = 4;
   localparam int CTRL_DLYUP_BIT = 5;
   localparam int CTRL_UPIRQ_BIT = 6;
   localparam int CTRL_WIDTH     = 7;

   // Interrupt status bit positions
   localparam int IRQ_UPD_BIT  = 0;
   localparam int IRQ_DONE_BIT = 1;
   localparam int IRQ_TRIG_BIT = 2;
   localparam int IRQ_WIDTH    = 3;

   localparam int DAC_WIDTH = 12;
   localparam int CNT_WIDTH = 16;

   localparam logic [CNT_WIDTH-1:0] CNT_RESET = 16'h0000;
   localparam logic [CNT_WIDTH-1:0] DIV_RESET = 16'h0010;

   // External convert edge spacing after trigger or scan edge
   localparam int SETUP_NS   = 50;
   localparam int CLK_PER_NS = 50;
   localparam int SETUP_CYC  = (SETUP_NS + CLK_PER_NS - 1) / CLK_PER_NS;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_WAIT  = 4'b0010,
      ST_RUN   = 4'b0100,
      ST_DONE  = 4'b1000
   } acq_state_t;

   typedef struct packed {
      logic upd_irq_en;
      logic delayed_update;
      logic ext_scan;
      logic scan_enable;
      logic stop_trigger_mode;
      logic ext_timing;
      logic arm;
   } ctrl_t;

   typedef struct packed {
      logic convert_pulse;
      logic gate;
      logic running;
   } acq_out_t;
endpackage

// File: hdl/acquisition_trigger_control.sv
// Acquisition trigger, convert pacing, scan gating and DAC update control
`timescale 1ns/10ps
module acquisition_trigger_control
   import acq_trig_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [ADDR_W-1:0]             paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          ext_convert_n,
   input  wire logic                          ext_acq_trigger,
   input  wire logic                          scan_interval_in,
   input  wire logic                          ext_dac_update_n,
   output logic                               convert_start,
   output logic                               acq_active,
   output logic [acq_trig_pkg::DAC_WIDTH-1:0] dac0_out,
   output logic [acq_trig_pkg::DAC_WIDTH-1:0] dac1_out,
   output logic                               dac_write_strobe,
   output logic                               host_interrupt
);
   import acq_trig_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] cv_s_q;
   logic [1:0] tr_s_q;
   logic [1:0] sc_s_q;
   logic [1:0] up_s_q;
   logic       cv_q;
   logic       tr_q;
   logic       up_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cv_s_q <= 2'b11;
         tr_s_q <= 2'b00;
         sc_s_q <= 2'b00;
         up_s_q <= 2'b11;
         cv_q   <= 1'b1;
         tr_q   <= 1'b0;
         up_q   <= 1'b1;
      end else begin
         cv_s_q <= {cv_s_q[0], ext_convert_n};
         tr_s_q <= {tr_s_q[0], ext_acq_trigger};
         sc_s_q <= {sc_s_q[0], scan_interval_in};
         up_s_q <= {up_s_q[0], ext_dac_update_n};
         cv_q   <= cv_s_q[1];
         tr_q   <= tr_s_q[1];
         up_q   <= up_s_q[1];
      end
   end

   wire cv_fall = cv_q & ~cv_s_q[1];
   wire cv_rise = ~cv_q & cv_s_q[1];
   wire tr_rise = ~tr_q & tr_s_q[1];
   wire up_rise = ~up_q & up_s_q[1];
   wire up_low  = ~up_s_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   ctrl_t                ctrl_q;
   logic [CNT_WIDTH-1:0] samp_div_q;
   logic [CNT_WIDTH-1:0] post_cnt_q;
   logic [CNT_WIDTH-1:0] scan_div_q;
   logic [DAC_WIDTH-1:0] dac0_hold_q;
   logic [DAC_WIDTH-1:0] dac1_hold_q;
   logic [IRQ_WIDTH-1:0] irq_stat_q;
   logic [IRQ_WIDTH-1:0] irq_mask_q;

   wire wr_en = psel & penable & pwrite;
   wire rd_en = psel & ~pwrite;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a[7:0] == ofs) && (a[1:0] == 2'b00);
   endfunction

   wire wr_ctrl  = wr_en & hit(paddr, CTRL_OFS);
   wire wr_sdiv  = wr_en & hit(paddr, SAMP_DIV_OFS);
   wire wr_post  = wr_en & hit(paddr, POST_CNT_OFS);
   wire wr_cdiv  = wr_en & hit(paddr, SCAN_DIV_OFS);
   wire wr_dac0  = wr_en & hit(paddr, DAC0_OFS);
   wire wr_dac1  = wr_en & hit(paddr, DAC1_OFS);
   wire wr_istat = wr_en & hit(paddr, IRQ_STAT_OFS);
   wire wr_imask = wr_en & hit(paddr, IRQ_MASK_OFS);
   wire mapped   = hit(paddr, CTRL_OFS) | hit(paddr, SAMP_DIV_OFS)
                 | hit(paddr, POST_CNT_OFS) | hit(paddr, SCAN_DIV_OFS)
                 | hit(paddr, DAC0_OFS) | hit(paddr, DAC1_OFS)
                 | hit(paddr, STATUS_OFS) | hit(paddr, IRQ_STAT_OFS)
                 | hit(paddr, IRQ_MASK_OFS);
   // Arming a new sequence re-enables the trigger input
   wire arm_wr   = wr_ctrl & pwdata[CTRL_ARM_BIT];

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   ////////////////////////////////////////////////////////////////////////////
   // Acquisition sequencer
   acq_state_t           st_q;
   acq_state_t           st_d;
   logic [CNT_WIDTH-1:0] sdiv_cnt_q;
   logic [CNT_WIDTH-1:0] cdiv_cnt_q;
   logic                 counting_q;
   logic                 gate_q;
   logic                 scan_pend_q;
   logic                 sc_d1_q;

   wire ext_t       = ctrl_q.ext_timing;
   wire int_tick    = (sdiv_cnt_q == CNT_RESET);
   wire running     = (st_q == ST_RUN);
   wire scan_src    = ctrl_q.ext_scan ? sc_s_q[1] : (cdiv_cnt_q == CNT_RESET);
   wire scan_rise   = scan_src & ~sc_d1_q;
   wire gate_ok     = ~ctrl_q.scan_enable | gate_q;
   // External edge paces conversions, else the internal interval counter
   wire conv_ev     = running & gate_ok & (ext_t ? cv_fall : int_tick);
   wire last_sample = counting_q & (post_cnt_q == 16'h0001);

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (arm_wr) begin
               st_d = pwdata[CTRL_STOPM_BIT] ? ST_RUN : ST_WAIT;
            end
         end
         ST_WAIT: begin
            // Start trigger; in external mode a convert rise must follow
            if (tr_rise) begin
               st_d = ext_t ? ST_WAIT : ST_RUN;
            end
            if (counting_q && ext_t && cv_rise) begin
               st_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (conv_ev && last_sample) begin
               st_d = ST_DONE;
            end
         end
         ST_DONE: begin
            if (arm_wr) begin
               st_d = pwdata[CTRL_STOPM_BIT] ? ST_RUN : ST_WAIT;
            end
         end
         default: st_d = ST_IDLE;
      endcase
      if (wr_ctrl && !pwdata[CTRL_ARM_BIT]) begin
         st_d = ST_IDLE;
      end
   end

   // One trigger per armed sequence, later edges are dropped
   wire trig_taken = tr_rise & ~counting_q & ((st_q == ST_WAIT) | running);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q        <= ST_IDLE;
         counting_q  <= 1'b0;
         sdiv_cnt_q  <= CNT_RESET;
         cdiv_cnt_q  <= CNT_RESET;
         post_cnt_q  <= CNT_RESET;
         gate_q      <= 1'b0;
         scan_pend_q <= 1'b0;
         sc_d1_q     <= 1'b0;
      end else begin
         st_q    <= st_d;
         sc_d1_q <= scan_src;
         // A trigger landing on a rearm write still counts as taken
         if (trig_taken) begin
            counting_q <= 1'b1;
         end else if (arm_wr) begin
            counting_q <= 1'b0;
         end
         // Interval counter restarts on a trigger edge seen in ST_WAIT
         if (tr_rise && st_q == ST_WAIT) begin
            sdiv_cnt_q <= samp_div_q;
         end else if (int_tick) begin
            sdiv_cnt_q <= samp_div_q;
         end else begin
            sdiv_cnt_q <= sdiv_cnt_q - 16'h0001;
         end
         cdiv_cnt_q <= (cdiv_cnt_q == CNT_RESET) ? scan_div_q
                                                  : cdiv_cnt_q - 16'h0001;
         if (wr_post) begin
            post_cnt_q <= pwdata[CNT_WIDTH-1:0];
         end else if (conv_ev && counting_q && post_cnt_q != CNT_RESET) begin
            post_cnt_q <= post_cnt_q - 16'h0001;
         end
         // Scan gate opens on the first convert rise after a scan edge
         // Arming drops a stale scan edge from an earlier run
         if (arm_wr) begin
            scan_pend_q <= 1'b0;
         end else if (scan_rise) begin
            scan_pend_q <= 1'b1;
         end else if (scan_pend_q && cv_rise) begin
            scan_pend_q <= 1'b0;
         end
         if (arm_wr) begin
            gate_q <= 1'b0;
         end else if (scan_pend_q && cv_rise) begin
            gate_q <= 1'b1;
         end else if (scan_rise) begin
            gate_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // DAC update and interrupts
   wire upd_now = ctrl_q.delayed_update ? up_low : 1'b1;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q      <= '0;
         samp_div_q  <= DIV_RESET;
         scan_div_q  <= DIV_RESET;
         dac0_hold_q <= '0;
         dac1_hold_q <= '0;
         dac0_out    <= '0;
         dac1_out    <= '0;
         irq_mask_q  <= '0;
         irq_stat_q  <= '0;
         convert_start    <= 1'b0;
         dac_write_strobe <= 1'b0;
         prdata      <= '0;
      end else begin
         if (wr_ctrl)  ctrl_q     <= ctrl_t'(pwdata[CTRL_WIDTH-1:0]);
         if (wr_sdiv)  samp_div_q <= pwdata[CNT_WIDTH-1:0];
         if (wr_cdiv)  scan_div_q <= pwdata[CNT_WIDTH-1:0];
         if (wr_imask) irq_mask_q <= pwdata[IRQ_WIDTH-1:0];
         if (wr_dac0)  dac0_hold_q <= pwdata[DAC_WIDTH-1:0];
         if (wr_dac1)  dac1_hold_q <= pwdata[DAC_WIDTH-1:0];
         dac_write_strobe <= wr_dac0 | wr_dac1;
         convert_start    <= conv_ev;
         // Hold registers reach the pins only when update is allowed
         if (upd_now) begin
            dac0_out <= wr_dac0 ? pwdata[DAC_WIDTH-1:0] : dac0_hold_q;
            dac1_out <= wr_dac1 ? pwdata[DAC_WIDTH-1:0] : dac1_hold_q;
         end
         // Set wins over a same-cycle write-one clear
         irq_stat_q <= (irq_stat_q & ~(wr_istat ? pwdata[IRQ_WIDTH-1:0] : 3'b000))
                     | {trig_taken,
                        st_q == ST_RUN && st_d == ST_DONE,
                        up_rise & ctrl_q.upd_irq_en};
         if (rd_en) begin
            prdata <= 32'h0000_0000;
            if (hit(paddr, CTRL_OFS))     prdata[CTRL_WIDTH-1:0] <= ctrl_q;
            if (hit(paddr, SAMP_DIV_OFS)) prdata[CNT_WIDTH-1:0]  <= samp_div_q;
            if (hit(paddr, POST_CNT_OFS)) prdata[CNT_WIDTH-1:0]  <= post_cnt_q;
            if (hit(paddr, SCAN_DIV_OFS)) prdata[CNT_WIDTH-1:0]  <= scan_div_q;
            if (hit(paddr, DAC0_OFS))     prdata[DAC_WIDTH-1:0]  <= dac0_hold_q;
            if (hit(paddr, DAC1_OFS))     prdata[DAC_WIDTH-1:0]  <= dac1_hold_q;
            if (hit(paddr, STATUS_OFS))   prdata[5:0] <= {gate_q, counting_q, st_q};
            if (hit(paddr, IRQ_STAT_OFS)) prdata[IRQ_WIDTH-1:0]  <= irq_stat_q;
            if (hit(paddr, IRQ_MASK_OFS)) prdata[IRQ_WIDTH-1:0]  <= irq_mask_q;
         end
      end
   end

   assign acq_active     = running;
   assign host_interrupt = |(irq_stat_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   conv_ext_a: assert property (@(posedge clk) disable iff (!reset_n)
      (running && ext_t && gate_ok && cv_fall) |=> convert_start)
      else $error("Convert fall did not start conversion");
   stop_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!counting_q && !wr_post) |=> $stable(post_cnt_q))
      else $error("Post count moved before trigger");
   done_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      (running && conv_ev && last_sample && !wr_ctrl) |=> st_q == ST_DONE)
      else $error("Run did not end at zero");
   trig_once_a: assert property (@(posedge clk) disable iff (!reset_n)
      (counting_q && !arm_wr) |=> counting_q)
      else $error("Trigger re-armed without software");
   start_int_a: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q == ST_WAIT && !ext_t && tr_rise && !wr_ctrl) |=> running)
      else $error("Trigger did not start run");
   start_ext_a: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q == ST_WAIT && ext_t && !counting_q && !tr_rise) |=> !running)
      else $error("Run started without trigger");
   dly_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ctrl_q.delayed_update && !up_low) |=> $stable(dac0_out))
      else $error("DAC changed without update strobe");
   imm_upd_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!ctrl_q.delayed_update && wr_dac0) |=> dac0_out == $past(pwdata[DAC_WIDTH-1:0]))
      else $error("Immediate DAC write not shown");
   upd_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
      (up_rise && ctrl_q.upd_irq_en) |=> irq_stat_q[IRQ_UPD_BIT])
      else $error("Update edge lost interrupt");
   conv_int_a: assert property (@(posedge clk) disable iff (!reset_n)
      (running && !ext_t && gate_ok && int_tick) |=> convert_start)
      else $error("Interval tick did not start conversion");
   post_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
      (conv_ev && counting_q && post_cnt_q != CNT_RESET && !wr_post)
      |=> post_cnt_q == $past(post_cnt_q) - 16'h0001)
      else $error("Post count did not step down");
   gate_shut_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ctrl_q.scan_enable && !gate_q) |=> !convert_start)
      else $error("Conversion outside scan gate");
   gate_open_a: assert property (@(posedge clk) disable iff (!reset_n)
      (scan_pend_q && cv_rise && !arm_wr) |=> gate_q)
      else $error("Convert rise did not open gate");
   wr_strobe_a: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_dac0 || wr_dac1) |=> dac_write_strobe)
      else $error("DAC write strobe missing");
   cv_done_c: cover property (@(posedge clk) disable iff (!reset_n) st_q == ST_DONE);
   cv_gate_c: cover property (@(posedge clk) disable iff (!reset_n) gate_q && convert_start);
   cv_irq_c: cover property (@(posedge clk) disable iff (!reset_n) host_interrupt);
   cv_stop_c: cover property (@(posedge clk) disable iff (!reset_n)
      trig_taken && ctrl_q.stop_trigger_mode);
   cv_dly_c: cover property (@(posedge clk) disable iff (!reset_n)
      ctrl_q.delayed_update && up_low);
endmodule

// File: testbench/ext_timing_model.sv
// External timing equipment model driving the acquisition control pins
`timescale 1ns/10ps
module ext_timing_model (
   input  wire logic clk,
   output logic      ext_convert_n,
   output logic      ext_acq_trigger,
   output logic      scan_interval_in,
   output logic      ext_dac_update_n
);
   initial begin
      ext_convert_n    = 1'b1;
      ext_acq_trigger  = 1'b0;
      scan_interval_in = 1'b0;
      ext_dac_update_n = 1'b1;
   end

   // Every level lasts 4 cycles, above the 1-cycle minimum the pins need
   task automatic wait4();
      repeat (4) @(posedge clk);
   endtask

   // Fall then rise; a rise never comes sooner than 200 ns after a trigger edge
   task automatic conv(input int n);
      repeat (n) begin
         ext_convert_n <= 1'b0;
         wait4();
         ext_convert_n <= 1'b1;
         wait4();
      end
   endtask

   task automatic trig();
      ext_acq_trigger <= 1'b1;
      wait4();
      ext_acq_trigger <= 1'b0;
      wait4();
   endtask

   task automatic scan();
      scan_interval_in <= 1'b1;
      wait4();
      scan_interval_in <= 1'b0;
      wait4();
   endtask

   task automatic upd();
      ext_dac_update_n <= 1'b0;
      wait4();
      ext_dac_update_n <= 1'b1;
      wait4();
   endtask
endmodule

// File: testbench/acquisition_trigger_control_tb_top.sv
// Self-checking bench for the acquisition trigger control block
`timescale 1ns/10ps
module acquisition_trigger_control_tb_top;
   import acq_trig_pkg::*;
   logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        ext_convert_n, ext_acq_trigger, scan_interval_in, ext_dac_update_n;
   logic        convert_start, acq_active, dac_write_strobe, host_interrupt, err;
   logic [DAC_WIDTH-1:0] dac0_out, dac1_out, v;
   int          n_mismatch, n_checks, n_conv, n_dacwr, k, m;
   logic [31:0] seed;

   acquisition_trigger_control u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_convert_n(ext_convert_n), .ext_acq_trigger(ext_acq_trigger),
      .scan_interval_in(scan_interval_in), .ext_dac_update_n(ext_dac_update_n),
      .convert_start(convert_start), .acq_active(acq_active), .dac0_out(dac0_out),
      .dac1_out(dac1_out), .dac_write_strobe(dac_write_strobe),
      .host_interrupt(host_interrupt));
   ext_timing_model u_ext (.clk(clk), .ext_convert_n(ext_convert_n),
      .ext_acq_trigger(ext_acq_trigger), .scan_interval_in(scan_interval_in),
      .ext_dac_update_n(ext_dac_update_n));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Pre-edge value seen here, so each one-cycle pulse counts once
   always @(posedge clk) if (convert_start === 1'b1) n_conv++;
   always @(posedge clk) if (dac_write_strobe === 1'b1) n_dacwr++;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Conversions expected: pre-trigger ones plus post-trigger ones up to the count
   function automatic int exp_conv(input int pre, input int post, input int cnt);
      return pre + ((cnt != 0 && post > cnt) ? cnt : post);
   endfunction

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // The wait ends once pready is high; only the watchdog ends a wait with no answer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic ctrl(input logic [6:0] c, input logic [15:0] cnt);
      apb(1'b1, CTRL_OFS, 32'h0000_0000);
      apb(1'b1, POST_CNT_OFS, {16'h0000, cnt});
      apb(1'b1, CTRL_OFS, {25'h0, c});
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      $display("mismatch t=%0t watchdog expired", $time);
      close_out();
   end

   initial begin
      seed = 32'd56;
      {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
      n_mismatch = 0;
      n_checks = 0;
      n_conv = 0;
      n_dacwr = 0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'h0, "ctrl reset");
      apb(1'b0, SAMP_DIV_OFS, 32'h0);
      chk(rd, {16'h0, DIV_RESET}, "sample div reset");
      apb(1'b0, 8'h24, 32'h0);
      chk({rd[30:0], err}, 32'h1, "unmapped read");
      $display("test reset done");
      // Start mode, external pacing: first pulse only enables
      k = 2 + int'(rnd() % 4);
      ctrl(7'b000_0011, 16'h0000);
      n_conv = 0;
      u_ext.conv(2);
      chk(n_conv, 0, "no convert before trigger");
      u_ext.trig();
      u_ext.conv(k);
      repeat (8) @(posedge clk);
      chk(n_conv, k - 1, "start ext conversions");
      n_conv = 0;
      u_ext.trig();
      u_ext.conv(2);
      repeat (8) @(posedge clk);
      chk(n_conv, 2, "retrigger ignored");
      $display("test start external done");
      // Stop mode: counter idle before trigger, run ends at zero
      k = 1 + int'(rnd() % 3);
      ctrl(7'b000_0111, 16'h0003);
      n_conv = 0;
      u_ext.conv(k);
      chk(acq_active, 1'b1, "running before trigger");
      u_ext.trig();
      u_ext.conv(5);
      repeat (8) @(posedge clk);
      chk(n_conv, exp_conv(k, 5, 3), "stop mode conversions");
      chk(acq_active, 1'b0, "stop mode halted");
      $display("test stop mode done");
      // External sample and scan timing: gate waits for a scan edge
      k = 2 + int'(rnd() % 3);
      ctrl(7'b001_1111, 16'h0000);
      n_conv = 0;
      u_ext.conv(2);
      chk(n_conv, 0, "gate closed before scan");
      u_ext.scan();
      u_ext.conv(k);
      repeat (8) @(posedge clk);
      chk(n_conv, k - 1, "scan gated conversions");
      $display("test scan gate done");
      // Start mode, internal pacing
      apb(1'b1, SAMP_DIV_OFS, 32'h0000_0003);
      ctrl(7'b000_0001, 16'h0004);
      n_conv = 0;
      repeat (40) @(posedge clk);
      chk(n_conv, 0, "internal waits for trigger");
      u_ext.trig();
      repeat (200) @(posedge clk);
      chk(n_conv, exp_conv(0, 99, 4), "internal paced count");
      u_ext.trig();
      repeat (60) @(posedge clk);
      chk(n_conv, 4, "trigger after done ignored");
      $display("test start internal done");
      // DAC immediate and delayed update, update interrupt
      v = 12'(rnd()) | 12'h001;
      apb(1'b1, CTRL_OFS, 32'h0);
      apb(1'b1, DAC0_OFS, {20'h0, v});
      repeat (3) @(posedge clk);
      chk(dac0_out, v, "immediate update");
      apb(1'b1, IRQ_STAT_OFS, 32'h0000_0007);
      apb(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
      apb(1'b1, CTRL_OFS, 32'h0000_0060);
      v = 12'(rnd()) | 12'h001;
      apb(1'b1, DAC1_OFS, {20'h0, v});
      repeat (8) @(posedge clk);
      chk(dac1_out, 12'h000, "delayed holds");
      chk(n_dacwr, 2, "dac write strobes");
      chk(host_interrupt, 1'b0, "no irq before update");
      u_ext.upd();
      chk(dac1_out, v, "delayed applied");
      chk(host_interrupt, 1'b1, "update irq");
      apb(1'b0, IRQ_STAT_OFS, 32'h0);
      chk(rd[0], 1'b1, "update status");
      apb(1'b1, IRQ_MASK_OFS, 32'h0);
      chk(host_interrupt, 1'b0, "masked");
      apb(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
      apb(1'b1, IRQ_STAT_OFS, 32'h0000_0001);
      chk(host_interrupt, 1'b0, "cleared");
      $display("test dac update done");
      close_out();
   end
endmodule
